// ### inc/sirq_pkg.sv
// Shared constants and state encodings of the serial interrupt link.
package sirq_pkg;

  // Number of interrupt data frames carried in one cycle.
  localparam int          FRAME_COUNT      = 16;
  localparam logic [4:0]  LAST_FRAME       = 5'h10;
  // Host clock index of the turnaround clock of the last frame (3 * 16 + 1).
  localparam logic [5:0]  LAST_FRAME_CLOCK = 6'h31;
  // Host clock index of the first sample clock (3 * 1 - 1).
  localparam logic [5:0]  FIRST_SAMPLE     = 6'h02;
  localparam logic [5:0]  FRAME_CLOCKS     = 6'h03;

  // Stop pulse widths in link clocks.
  localparam logic [2:0]  STOP_LOW_QUIET   = 3'h2;
  localparam logic [2:0]  STOP_LOW_CONT    = 3'h3;
  // Host extension of the start pulse in link clocks.
  localparam logic [2:0]  START_EXTRA_MIN  = 3'h3;
  localparam logic [2:0]  START_EXTRA_MAX  = 3'h7;

  // Reported level of every interrupt line after reset.
  localparam logic [15:0] IRQ_IDLE_LEVEL   = 16'hffff;

  // Host system clocks per half period of the link clock it generates.
  localparam logic [3:0]  LINK_HALF_CYCLES = 4'h1;
  // Link clocks for which the host holds the bus reset drive after its own reset.
  localparam logic [3:0]  RESET_TICKS      = 4'h8;

  typedef enum logic [4:0] {
    DEV_IDLE   = 5'h01,
    DEV_START  = 5'h02,
    DEV_FRAMES = 5'h04,
    DEV_STOP   = 5'h08,
    DEV_HOLD   = 5'h10
  } dev_state_t;

  typedef enum logic [2:0] {
    PH_SAMPLE  = 3'h1,
    PH_RECOVER = 3'h2,
    PH_TURN    = 3'h4
  } phase_t;

  typedef enum logic [5:0] {
    HOST_IDLE   = 6'h01,
    HOST_START  = 6'h02,
    HOST_FRAMES = 6'h04,
    HOST_STOP   = 6'h08,
    HOST_TURN   = 6'h10,
    HOST_RESET  = 6'h20
  } host_state_t;

endpackage

// ### inc/sirq_link_if.sv
// Shared serial interrupt line between the host end and the device end.
`timescale 1ns/1ps
interface sirq_link_if;
  logic pci_bus_clock;
  logic bus_reset_drive;
  logic host_o;
  logic host_oe;
  logic dev_o;
  logic dev_oe;
  logic serial_interrupt_line;

  // Open line with a pull-up: an undriven line reads high, a low drive wins.
  assign serial_interrupt_line = (host_oe ? host_o : 1'b1) & (dev_oe ? dev_o : 1'b1);

  modport host (
    output pci_bus_clock,
    output bus_reset_drive,
    output host_o,
    output host_oe,
    input  serial_interrupt_line
  );

  modport device (
    input  pci_bus_clock,
    input  bus_reset_drive,
    output dev_o,
    output dev_oe,
    input  serial_interrupt_line
  );
endinterface

// ### rtl/sirq_sync.sv
// Two-stage level synchroniser into the domain of its clock.
`timescale 1ns/1ps
module sirq_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] init,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  // Reset loads the init value through the clocked path, so no port reaches an asynchronous load.
  always_comb begin
    next_meta = rst ? init : d;
    next_q    = rst ? init : meta;
  end

  always_ff @(posedge clk) begin
    meta <= next_meta;
    q    <= next_q;
  end
endmodule // sirq_sync

// ### rtl/sirq_device.sv
// Serial interrupt slave end: frame timing on the link clock, interrupt levels from the system clock.
//
// Summary of operation
// - Quiet mode: start frame, one low clock, idle line.
// - After start clock release, never drive high.
// - Never start a frame during an active cycle.
// - Host extends start low three to seven clocks.
// - Host drives high one clock, then releases.
// - Interrupt change in quiet mode requests start frame.
// - Continuous mode: device never starts a frame.
// - Continuous mode: host makes four-to-eight-clock start pulse.
// - Host may restart after every stop frame.
// - Mode changes only inside the stop frame.
// - Reset selects continuous mode.
// - Stop low two clocks quiet, three continuous.
// - Stop width measured on every cycle.
// - Idle clocks inside stop frame are tolerated.
// - Next start right after turnaround or later.
// - Idle from stop to start, else active.
// - Three-clock frames; sample drives low on low value.
// - Recovery high only after own low; turnaround released.
// - Frame n sample clock is 3n-1 after rise.
// - Line released while bus reset drive is active.
`timescale 1ns/1ps
module sirq_device (
  input  wire logic                             clk,
  input  wire logic                             srst,
  input  wire logic [sirq_pkg::FRAME_COUNT-1:0] irq_level,
  output logic                                  quiet_mode,
  output logic                                  cycle_active,
  sirq_link_if.device                           link
);
  import sirq_pkg::*;

  // System clock side: interrupt levels are registered before they cross.
  logic [FRAME_COUNT-1:0] irq_src;
  logic [FRAME_COUNT-1:0] next_irq_src;

  always_comb begin
    next_irq_src = srst ? IRQ_IDLE_LEVEL : irq_level;
  end

  always_ff @(posedge clk) begin
    irq_src <= next_irq_src;
  end

  // Link clock side state.
  logic                   link_rst;
  logic                   line;
  logic [FRAME_COUNT-1:0] irq_link;
  dev_state_t             state;
  dev_state_t             next_state;
  phase_t                 phase;
  phase_t                 next_phase;
  logic [4:0]             frame;
  logic [4:0]             next_frame;
  logic [2:0]             low_cnt;
  logic [2:0]             next_low_cnt;
  logic                   mode_quiet;
  logic                   next_mode_quiet;
  logic [FRAME_COUNT-1:0] reported;
  logic [FRAME_COUNT-1:0] next_reported;
  logic                   drive_o;
  logic                   next_drive_o;
  logic                   drive_oe;
  logic                   next_drive_oe;
  logic                   link_active;
  logic                   next_link_active;
  logic                   pending;
  logic                   slot_level;

  assign link_rst = link.bus_reset_drive;
  // The line changes only on link clock edges, so it is read directly in this domain.
  assign line     = link.serial_interrupt_line;

  sirq_sync #(
    .WIDTH (FRAME_COUNT)
  ) irq_to_link (
    .clk  (link.pci_bus_clock),
    .rst  (link_rst),
    .init (IRQ_IDLE_LEVEL),
    .d    (irq_src),
    .q    (irq_link)
  );

  // A change seen after its own slot has passed stays pending, so it is carried by a later cycle.
  assign pending    = |(irq_link ^ reported);
  assign slot_level = irq_link[frame[3:0]];

  always_comb begin
    next_state      = state;
    next_phase      = phase;
    next_frame      = frame;
    next_low_cnt    = low_cnt;
    next_mode_quiet = mode_quiet;
    next_reported   = reported;
    next_drive_o    = 1'b1;
    next_drive_oe   = 1'b0;
    case (state)
      DEV_IDLE: begin
        if (!line) begin
          next_state = DEV_START;
        end else if (mode_quiet && pending) begin
          // One low clock only; the host takes over the start pulse.
          next_drive_o  = 1'b0;
          next_drive_oe = 1'b1;
          next_state    = DEV_START;
        end
      end
      DEV_START: begin
        // Own start drive ends here and nothing is driven high.
        if (line) begin
          next_state = DEV_FRAMES;
          next_phase = PH_TURN;
          next_frame = 5'h00;
        end
      end
      DEV_FRAMES: begin
        case (phase)
          PH_TURN: begin
            if (frame == LAST_FRAME) begin
              next_state   = DEV_STOP;
              next_low_cnt = 3'h0;
            end else begin
              next_phase              = PH_SAMPLE;
              next_frame              = frame + 5'h01;
              next_reported[frame[3:0]] = slot_level;
              next_drive_o            = 1'b0;
              next_drive_oe           = !slot_level;
            end
          end
          PH_SAMPLE: begin
            next_phase    = PH_RECOVER;
            next_drive_o  = 1'b1;
            next_drive_oe = drive_oe;
          end
          PH_RECOVER: begin
            next_phase = PH_TURN;
          end
          default: begin
            next_phase = PH_TURN;
          end
        endcase
      end
      DEV_STOP: begin
        // Idle clocks before the stop pulse simply leave the counter at zero.
        if (!line) begin
          if (low_cnt != START_EXTRA_MAX) begin
            next_low_cnt = low_cnt + 3'h1;
          end
        end else if (low_cnt != 3'h0) begin
          next_low_cnt = 3'h0;
          if (low_cnt == STOP_LOW_QUIET) begin
            next_mode_quiet = 1'b1;
            next_state      = DEV_HOLD;
          end else if (low_cnt == STOP_LOW_CONT) begin
            next_mode_quiet = 1'b0;
            next_state      = DEV_HOLD;
          end
        end
      end
      DEV_HOLD: begin
        // A device start is allowed from the third clock after the stop rising edge.
        next_state = line ? DEV_IDLE : DEV_START;
      end
      default: begin
        next_state = DEV_IDLE;
      end
    endcase
    if (!mode_quiet && (state == DEV_IDLE) && next_drive_oe) begin
      next_drive_oe = 1'b0;
    end
    next_link_active = (next_state == DEV_START) || (next_state == DEV_FRAMES);
    if (link_rst) begin
      next_state       = DEV_IDLE;
      next_phase       = PH_TURN;
      next_frame       = 5'h00;
      next_low_cnt     = 3'h0;
      next_mode_quiet  = 1'b0;
      next_reported    = IRQ_IDLE_LEVEL;
      next_drive_o     = 1'b1;
      next_drive_oe    = 1'b0;
      next_link_active = 1'b0;
    end
  end

  always_ff @(posedge link.pci_bus_clock) begin
    state       <= next_state;
    phase       <= next_phase;
    frame       <= next_frame;
    low_cnt     <= next_low_cnt;
    mode_quiet  <= next_mode_quiet;
    reported    <= next_reported;
    drive_o     <= next_drive_o;
    drive_oe    <= next_drive_oe;
    link_active <= next_link_active;
  end

  // The enable is gated by the reset level itself so the line is free from the first reset clock.
  assign link.dev_oe = drive_oe & ~link_rst;
  assign link.dev_o  = drive_o;

  // Status back into the system clock domain.
  logic [1:0] status_sys;

  sirq_sync #(
    .WIDTH (2)
  ) status_to_sys (
    .clk  (clk),
    .rst  (srst),
    .init (2'h0),
    .d    ({mode_quiet, link_active}),
    .q    (status_sys)
  );

  assign quiet_mode   = status_sys[1];
  assign cycle_active = status_sys[0];

endmodule // sirq_device

// ### rtl/sirq_host.sv
// Serial interrupt host end: link clock generation, start and stop pulses, frame sampling.
`timescale 1ns/1ps
module sirq_host (
  input  wire logic                             clk,
  input  wire logic                             srst,
  input  wire logic                             cycle_req,
  input  wire logic                             run_continuous,
  input  wire logic                             quiet_next,
  input  wire logic [2:0]                       start_extra,
  output logic      [sirq_pkg::FRAME_COUNT-1:0] irq_state,
  output logic                                  irq_valid,
  sirq_link_if.host                             link
);
  import sirq_pkg::*;

  function automatic logic [2:0] start_len(input logic [2:0] req);
    start_len = (req < START_EXTRA_MIN) ? START_EXTRA_MIN : req;
  endfunction

  function automatic logic [3:0] slot_of(input logic [5:0] c);
    logic [5:0] s;
    s       = (c - FIRST_SAMPLE) / FRAME_CLOCKS;
    slot_of = s[3:0];
  endfunction

  host_state_t            state;
  host_state_t            next_state;
  logic [3:0]             div_cnt;
  logic [3:0]             next_div_cnt;
  logic                   pclk;
  logic                   next_pclk;
  logic                   tick;
  logic [3:0]             rst_cnt;
  logic [3:0]             next_rst_cnt;
  logic                   rst_drv;
  logic                   next_rst_drv;
  logic [5:0]             cnt;
  logic [5:0]             next_cnt;
  logic                   req_pend;
  logic                   next_req_pend;
  logic                   quiet_sel;
  logic                   next_quiet_sel;
  logic                   h_o;
  logic                   next_h_o;
  logic                   h_oe;
  logic                   next_h_oe;
  logic [FRAME_COUNT-1:0] shadow;
  logic [FRAME_COUNT-1:0] next_shadow;
  logic [FRAME_COUNT-1:0] next_irq_state;
  logic                   next_irq_valid;
  logic                   fall;
  logic                   out_o;
  logic                   next_out_o;
  logic                   out_oe;
  logic                   next_out_oe;
  logic                   out_rst;
  logic                   next_out_rst;

  // The link clock is divided from clk; sampling and state changes happen on the edge that raises it.
  assign tick = (div_cnt == LINK_HALF_CYCLES - 4'h1) && !pclk;
  assign fall = (div_cnt == LINK_HALF_CYCLES - 4'h1) && pclk;

  // Link outputs move on the edge that lowers the link clock.
  // Launching them with the rising edge would race the device flops clocked by that same edge.
  always_comb begin
    next_out_o   = fall ? h_o : out_o;
    next_out_oe  = fall ? (h_oe & ~rst_drv) : out_oe;
    next_out_rst = fall ? rst_drv : out_rst;
    if (srst) begin
      next_out_o   = 1'b1;
      next_out_oe  = 1'b0;
      next_out_rst = 1'b1;
    end
  end

  always_comb begin
    next_div_cnt   = (div_cnt == LINK_HALF_CYCLES - 4'h1) ? 4'h0 : div_cnt + 4'h1;
    next_pclk      = (div_cnt == LINK_HALF_CYCLES - 4'h1) ? !pclk : pclk;
    next_state     = state;
    next_rst_cnt   = rst_cnt;
    next_rst_drv   = rst_drv;
    next_cnt       = cnt;
    next_req_pend  = req_pend | cycle_req;
    next_quiet_sel = quiet_sel;
    next_h_o       = h_o;
    next_h_oe      = h_oe;
    next_shadow    = shadow;
    next_irq_state = irq_state;
    next_irq_valid = 1'b0;
    if (tick) begin
      next_h_o  = 1'b1;
      next_h_oe = 1'b0;
      case (state)
        HOST_RESET: begin
          next_rst_cnt = rst_cnt + 4'h1;
          if (rst_cnt == RESET_TICKS - 4'h1) begin
            next_rst_drv = 1'b0;
            next_state   = HOST_IDLE;
          end
        end
        HOST_IDLE: begin
          if (!link.serial_interrupt_line) begin
            // A device drove the first start clock; extend it.
            next_h_o   = 1'b0;
            next_h_oe  = 1'b1;
            next_cnt   = {3'h0, start_len(start_extra)} - 6'h1;
            next_state = HOST_START;
          end else if (req_pend || run_continuous) begin
            next_h_o      = 1'b0;
            next_h_oe     = 1'b1;
            next_cnt      = {3'h0, start_len(start_extra)};
            next_req_pend = cycle_req;
            next_state    = HOST_START;
          end
        end
        HOST_START: begin
          next_h_oe = 1'b1;
          if (cnt == 6'h0) begin
            next_h_o   = 1'b1;
            next_state = HOST_FRAMES;
          end else begin
            next_h_o = 1'b0;
            next_cnt = cnt - 6'h1;
          end
        end
        HOST_FRAMES: begin
          // cnt is the index of the link clock that just ended, counted from the rising edge.
          if ((cnt >= FIRST_SAMPLE) && ((cnt - FIRST_SAMPLE) % FRAME_CLOCKS == 6'h0)) begin
            next_shadow[slot_of(cnt)] = link.serial_interrupt_line;
          end
          if (cnt == LAST_FRAME_CLOCK) begin
            next_quiet_sel = quiet_next;
            next_h_o       = 1'b0;
            next_h_oe      = 1'b1;
            next_cnt       = {3'h0, (quiet_next ? STOP_LOW_QUIET : STOP_LOW_CONT)} - 6'h1;
            next_state     = HOST_STOP;
            next_irq_state = shadow;
            next_irq_valid = 1'b1;
          end else begin
            next_cnt = cnt + 6'h1;
          end
        end
        HOST_STOP: begin
          next_h_oe = 1'b1;
          if (cnt == 6'h0) begin
            next_h_o   = 1'b1;
            next_state = HOST_TURN;
          end else begin
            next_h_o = 1'b0;
            next_cnt = cnt - 6'h1;
          end
        end
        HOST_TURN: begin
          // Released turnaround clock; a new start may follow right after it.
          next_state = HOST_IDLE;
        end
        default: begin
          next_state = HOST_IDLE;
        end
      endcase
      // The first cycle after the frames holds sampled data from the last frame too.
      if (state == HOST_FRAMES && cnt == LAST_FRAME_CLOCK) begin
        next_cnt = next_cnt;
      end
    end
    if (state == HOST_START && cnt == 6'h0 && tick) begin
      next_cnt = 6'h0;
    end
    if (srst) begin
      next_div_cnt   = 4'h0;
      next_pclk      = 1'b0;
      next_state     = HOST_RESET;
      next_rst_cnt   = 4'h0;
      next_rst_drv   = 1'b1;
      next_cnt       = 6'h0;
      next_req_pend  = 1'b0;
      next_quiet_sel = 1'b0;
      next_h_o       = 1'b1;
      next_h_oe      = 1'b0;
      next_shadow    = IRQ_IDLE_LEVEL;
      next_irq_state = IRQ_IDLE_LEVEL;
      next_irq_valid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    div_cnt   <= next_div_cnt;
    pclk      <= next_pclk;
    state     <= next_state;
    rst_cnt   <= next_rst_cnt;
    rst_drv   <= next_rst_drv;
    cnt       <= next_cnt;
    req_pend  <= next_req_pend;
    quiet_sel <= next_quiet_sel;
    h_o       <= next_h_o;
    h_oe      <= next_h_oe;
    shadow    <= next_shadow;
    irq_state <= next_irq_state;
    irq_valid <= next_irq_valid;
    out_o     <= next_out_o;
    out_oe    <= next_out_oe;
    out_rst   <= next_out_rst;
  end

  assign link.pci_bus_clock   = pclk;
  assign link.bus_reset_drive = out_rst;
  assign link.host_o          = out_o;
  assign link.host_oe         = out_oe & ~out_rst;

endmodule // sirq_host

// ### verification/sirq_link_checker.sv
// Protocol assertions on the shared serial interrupt line.
`timescale 1ns/1ps
module sirq_link_checker (
  input wire logic pci_bus_clock,
  input wire logic bus_reset_drive,
  input wire logic host_o,
  input wire logic host_oe,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic serial_interrupt_line
);
  logic [3:0] low_run;
  logic [3:0] next_low_run;
  logic [5:0] pos;
  logic [5:0] next_pos;
  logic       quiet_seen;
  logic       next_quiet_seen;
  logic       start_rise;
  logic       stop_rise;
  logic       dev_low;

  // A start pulse is at least four low clocks, so shorter runs after the frames are stop pulses.
  assign start_rise = serial_interrupt_line && (low_run >= 4'h4);
  assign stop_rise  = serial_interrupt_line && (low_run != 4'h0) && (low_run < 4'h4) && (pos > 6'h31);
  assign dev_low    = dev_oe && !dev_o;

  always_comb begin
    next_low_run    = low_run;
    next_pos        = pos;
    next_quiet_seen = quiet_seen;
    if (bus_reset_drive) begin
      next_low_run    = 4'h0;
      next_pos        = 6'h3f;
      next_quiet_seen = 1'b0;
    end else begin
      if (serial_interrupt_line) next_low_run = 4'h0;
      else if (low_run != 4'hf) next_low_run = low_run + 4'h1;
      // The edge that sees the high clock 0 loads the index of the clock that follows it.
      if (start_rise) next_pos = 6'h01;
      else if (pos != 6'h3f) next_pos = pos + 6'h01;
      if (stop_rise && (low_run == 4'h2)) next_quiet_seen = 1'b1;
      if (stop_rise && (low_run == 4'h3)) next_quiet_seen = 1'b0;
    end
  end

  always_ff @(posedge pci_bus_clock) begin
    low_run    <= next_low_run;
    pos        <= next_pos;
    quiet_seen <= next_quiet_seen;
  end

  default clocking cb @(posedge pci_bus_clock);
  endclocking
  default disable iff (bus_reset_drive);

  sequence s_host_high_release;
    host_oe && host_o ##1 !host_oe;
  endsequence

  sequence s_own_low_then_high;
    dev_low ##1 (dev_oe && dev_o);
  endsequence

  a_reset_released: assert property (disable iff (1'b0) bus_reset_drive |-> !dev_oe && !host_oe)
    else $error("line driven during bus reset");
  a_start_width: assert property (start_rise |-> low_run <= 4'h8)
    else $error("start pulse longer than eight clocks");
  a_host_high_one: assert property (start_rise |-> s_host_high_release)
    else $error("host did not drive high one clock then release");
  a_sample_slot: assert property (dev_low && (pos <= 6'h31) |-> (pos % 6'h03) == 6'h02)
    else $error("device drove low outside a sample clock");
  a_recover_own: assert property ((dev_oe && dev_o) |-> $past(dev_low) && ((pos % 6'h03) == 6'h00))
    else $error("device drove high without its own low");
  a_turn_release: assert property ((pos >= 6'h04) && (pos <= 6'h31) && ((pos % 6'h03) == 6'h01) |-> !dev_oe)
    else $error("device drove in a turnaround clock");
  a_start_single: assert property (dev_low && (pos > 6'h31) |=> !dev_oe [*3])
    else $error("device start not a single low clock then release");
  a_start_idle: assert property (dev_low && (pos > 6'h31) |-> low_run == 4'h0)
    else $error("device started while line not idle");
  a_cont_passive: assert property (dev_low && (pos > 6'h31) |-> quiet_seen)
    else $error("device started outside quiet mode");
  a_stop_width: assert property (stop_rise |-> low_run >= 4'h2)
    else $error("stop pulse shorter than two clocks");
  c_dev_start: cover property (s_own_low_then_high or (dev_low && (pos > 6'h31)));
endmodule // sirq_link_checker

// ### verification/serial_irq_cycle_control_tb.sv
// Self-checking bench joining the serial interrupt host and device ends.
`timescale 1ns/1ps
module serial_irq_cycle_control_tb;
  import sirq_pkg::*;

  typedef struct packed {
    logic        req;
    logic [2:0]  extra;
    logic        quiet;
    logic [15:0] level;
  } row_t;

  localparam int ROWS        = 7;
  localparam int CYCLE_LIMIT = 20000;

  logic        clk;
  logic        srst;
  logic [15:0] irq_level;
  logic        cycle_req;
  logic        run_continuous;
  logic        quiet_next;
  logic [2:0]  start_extra;
  logic [15:0] irq_state;
  logic        irq_valid;
  logic        quiet_mode;
  logic        cycle_active;
  int          num_errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  bit          seen;
  row_t        rows [ROWS];

  sirq_link_if link_bus ();

  sirq_host i_sirq_host (
    .clk            (clk),
    .srst           (srst),
    .cycle_req      (cycle_req),
    .run_continuous (run_continuous),
    .quiet_next     (quiet_next),
    .start_extra    (start_extra),
    .irq_state      (irq_state),
    .irq_valid      (irq_valid),
    .link           (link_bus)
  );

  sirq_device i_sirq_device (
    .clk          (clk),
    .srst         (srst),
    .irq_level    (irq_level),
    .quiet_mode   (quiet_mode),
    .cycle_active (cycle_active),
    .link         (link_bus)
  );

  sirq_link_checker i_sirq_link_checker (
    .pci_bus_clock         (link_bus.pci_bus_clock),
    .bus_reset_drive       (link_bus.bus_reset_drive),
    .host_o                (link_bus.host_o),
    .host_oe               (link_bus.host_oe),
    .dev_o                 (link_bus.dev_o),
    .dev_oe                (link_bus.dev_oe),
    .serial_interrupt_line (link_bus.serial_interrupt_line)
  );

  always #50 clk = ~clk;

  task final_report;
    $display("Checks: %0d, errors: %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // A hang anywhere counts against the run instead of stalling it.
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == CYCLE_LIMIT) begin
      num_errors = num_errors + 1;
      final_report();
    end
  end

  task check(input logic [15:0] got, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wait_valid(input int limit, output bit hit);
    int n;
    hit = 1'b0;
    n = 0;
    while (!hit && n < limit) begin
      @(negedge clk);
      n = n + 1;
      if (irq_valid === 1'b1) hit = 1'b1;
    end
  endtask

  // The line counts as settled once no cycle has been active for a full cycle length.
  task wait_idle;
    int run;
    int n;
    run = 0;
    n = 0;
    while (run < 160 && n < 3000) begin
      @(negedge clk);
      n = n + 1;
      run = (cycle_active === 1'b0) ? run + 1 : 0;
    end
    check({15'h0000, cycle_active}, 16'h0000);
  endtask

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    irq_level = 16'hffff;
    cycle_req = 1'b0;
    run_continuous = 1'b0;
    quiet_next = 1'b0;
    start_extra = 3'h3;
    // Rows without a request rely on the device starting the cycle itself in quiet mode.
    rows[0] = '{1'b1, 3'h3, 1'b1, 16'hfffe};
    rows[1] = '{1'b0, 3'h4, 1'b1, 16'h7fff};
    rows[2] = '{1'b0, 3'h7, 1'b0, 16'ha5a5};
    rows[3] = '{1'b1, 3'h5, 1'b0, 16'h5a5a};
    rows[4] = '{1'b1, 3'h0, 1'b1, 16'h0000};
    rows[5] = '{1'b0, 3'h6, 1'b0, 16'hffff};
    rows[6] = '{1'b1, 3'h7, 1'b0, 16'h1234};
    repeat (4) @(negedge clk);
    check(irq_state, IRQ_IDLE_LEVEL);
    srst = 1'b0;
    check({15'h0000, quiet_mode}, 16'h0000);
    for (int i = 0; i < ROWS; i++) begin
      @(negedge clk);
      start_extra = rows[i].extra;
      quiet_next = rows[i].quiet;
      irq_level = rows[i].level;
      cycle_req = rows[i].req;
      @(negedge clk);
      cycle_req = 1'b0;
      wait_valid(1000, seen);
      check({15'h0000, seen}, 16'h0001);
      check(irq_state, rows[i].level);
      wait_idle();
      check({15'h0000, quiet_mode}, {15'h0000, rows[i].quiet});
    end
    irq_level = 16'hbeef;
    wait_valid(400, seen);
    check({15'h0000, seen}, 16'h0000);
    check(irq_state, 16'h1234);
    run_continuous = 1'b1;
    wait_valid(1000, seen);
    check(irq_state, 16'hbeef);
    wait_valid(400, seen);
    check({15'h0000, seen}, 16'h0001);
    run_continuous = 1'b0;
    wait_idle();
    // Reset again with a cycle in flight; the line must be released and the mode fall back.
    cycle_req = 1'b1;
    @(negedge clk);
    cycle_req = 1'b0;
    for (int n = 0; n < 500 && cycle_active !== 1'b1; n++) @(negedge clk);
    srst = 1'b1;
    repeat (4) @(negedge clk);
    check(irq_state, IRQ_IDLE_LEVEL);
    check({15'h0000, irq_valid}, 16'h0000);
    srst = 1'b0;
    @(negedge clk);
    check({15'h0000, quiet_mode}, 16'h0000);
    cycle_req = 1'b1;
    @(negedge clk);
    cycle_req = 1'b0;
    wait_valid(1000, seen);
    check(irq_state, 16'hbeef);
    final_report();
  end
endmodule // serial_irq_cycle_control_tb
